// ===== iss_defines.svh
// offsets, field positions, reset values and timing counts of the slave/stop/restart bus block
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

// register offsets on the plain register port
`define ISS_OFS_CTRL1      8'h20
`define ISS_OFS_DBR        8'h21
`define ISS_OFS_CTRL2      8'h23
`define ISS_OFS_OWN        8'h24

// ctrl_reg_two write fields, bus_status_reg read fields
`define ISS_BIT_MST        7
`define ISS_BIT_TRX        6
`define ISS_BIT_BB         5
`define ISS_BIT_PIN        4
`define ISS_BIT_AL         3
`define ISS_BIT_AAS        2
`define ISS_BIT_AD0        1
`define ISS_BIT_LRB        0

// control register one fields
`define ISS_BIT_ACK        4
`define ISS_WBC_HI         7
`define ISS_WBC_LO         5

// reset values
`define ISS_PIN_RST        1'b1
`define ISS_WBC_RST        3'h0
`define ISS_ACK_RST        1'b0
`define ISS_OWN_RST        7'h00

// timing
`define ISS_CLK_NS         10
`define ISS_SCL_LOW_NS     4700
`define ISS_STOP_SU_NS     4000
`define ISS_SCL_LOW_CYC    ((`ISS_SCL_LOW_NS + `ISS_CLK_NS - 1) / `ISS_CLK_NS)
`define ISS_STOP_SU_CYC    ((`ISS_STOP_SU_NS + `ISS_CLK_NS - 1) / `ISS_CLK_NS)

`endif

// ===== iss_pkg.sv
// types shared by the slave/stop/restart bus block
package iss_pkg;

  // transfer sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DACK = 6'h10,
    ST_STOP = 6'h20
  } iss_state_t;

  // bus_status_reg layout, msb first
  typedef struct packed {
    logic master_select;
    logic direction_tx;
    logic bb;
    logic pin;
    logic al;
    logic addressed_as_slave;
    logic ad0;
    logic last_rx_bit;
  } iss_status_t;

endpackage

// ===== iss_pin_sync.sv
// two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ns
`default_nettype none

module iss_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw line and synchronised view
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // lines idle high, so reset to one to avoid a false edge at release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // only the second and third stage are looked at
  assign level = s2_r;
  assign rise  = s2_r & ~s3_r;
  assign fall  = ~s2_r & s3_r;

endmodule

`default_nettype wire

// ===== iss_core.sv
// slave-mode handling, clock hold, stop and restart sequencing of the two-wire bus interface
`timescale 1ns/1ns
`default_nettype none
`include "iss_defines.svh"

// Functional notes
// RULE1 - interrupt on own address or general call match, and after each following word
// RULE2 - noise as master drops to slave; interrupt when current word ends
// RULE3 - each interrupt clears clock-hold release flag; clock held low while zero
// RULE4 - data buffer access or writing one to flag releases clock after low time
// RULE5 - status bits: lost-arb 3, direction 6, addressed 2, general call 1
// RULE6 - own address with read bit shows direction 1, addressed 1, others 0
// RULE7 - software tests last bit after slave transmit, then frees bus or reloads
// RULE8 - noise during transfer ends word, shows lost-arb only; software recovers
// RULE9 - after write-direction address, software dummy-reads buffer or sets flag
// RULE10 - after slave received word, software sets bit count and reads buffer
// RULE11 - master, direction, release set with busy cleared starts stop sequence
// RULE12 - software leaves control bits alone until stop appears on bus
// RULE13 - stop waits while another device holds clock line low
// RULE14 - restart keeps data high and releases clock without any stop
// RULE15 - software polls busy flag until own clock pin is released
// RULE16 - software polls last bit until clock line free, then starts again
// RULE17 - software waits 4.7 us before issuing new start after restart
// RULE18 - master transmit compares data pin to line; mismatch loses arbitration
// RULE19 - data line captured into last received bit at each clock rise
// RULE20 - writing one sets release flag, zero leaves it; interrupt clears it
// RULE21 - addressed-as-slave cleared by any data buffer read or write
// RULE22 - bit count sets data bits per word before acknowledge and interrupt
module iss_core #(
  parameter int unsigned LOW_CYC = `ISS_SCL_LOW_CYC,
  parameter int unsigned SU_CYC  = `ISS_STOP_SU_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // serial clock pin, open drain
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  // serial data pin, open drain
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // interrupt request pulse
  output logic            bus_iface_irq
);

  iss_pkg::iss_state_t  state_r;
  iss_pkg::iss_state_t  state_nxt;
  iss_pkg::iss_status_t status_w;

  logic        scl_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_s;
  logic        sda_rise;
  logic        sda_fall;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_sh_r;
  logic        mst_r;
  logic        trx_r;
  logic        busy_r;
  logic        pin_r;
  logic        al_r;
  logic        aas_r;
  logic        ad0_r;
  logic        lrb_r;
  logic        restart_r;
  logic [2:0]  wbc_r;
  logic        ack_en_r;
  logic [6:0]  own_r;
  logic [15:0] rel_cnt_r;
  logic [15:0] su_cnt_r;
  logic        stop_sda_r;
  logic        irq_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic [7:0]  rdata_r;
  logic        sda_low_nxt;

  // line synchronisers
  iss_pin_sync u_scl_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (scl_i),
    .level  (scl_s),
    .rise   (scl_rise),
    .fall   (scl_fall)
  );

  iss_pin_sync u_sda_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (sda_i),
    .level  (sda_s),
    .rise   (sda_rise),
    .fall   (sda_fall)
  );

  // bus conditions and register decode
  wire start_det = sda_fall & scl_s;
  wire stop_det  = sda_rise & scl_s;
  wire bus_evt   = start_det | stop_det;
  wire wr_ctrl   = reg_wr & (reg_addr == `ISS_OFS_CTRL2);
  wire wr_ctrl1  = reg_wr & (reg_addr == `ISS_OFS_CTRL1);
  wire wr_own    = reg_wr & (reg_addr == `ISS_OFS_OWN);
  wire wr_dbr    = reg_wr & (reg_addr == `ISS_OFS_DBR);
  wire rd_dbr    = reg_rd & (reg_addr == `ISS_OFS_DBR);
  wire dbr_acc   = wr_dbr | rd_dbr;
  wire w_mst     = reg_wdata[`ISS_BIT_MST];
  wire w_trx     = reg_wdata[`ISS_BIT_TRX];
  wire w_bb      = reg_wdata[`ISS_BIT_BB];
  wire w_pin     = reg_wdata[`ISS_BIT_PIN];

  // stop and restart commands are recognised from the upper four ctrl bits
  wire stop_req  = wr_ctrl & busy_r & w_mst & w_trx & ~w_bb & w_pin;     // [RULE11]
  wire rst_req   = wr_ctrl & ~w_mst & ~w_trx & ~w_bb & w_pin;            // [RULE14]

  // word length: a zero count means a full eight bits
  wire [3:0] word_len = (wbc_r == 3'h0) ? 4'h8 : {1'b0, wbc_r};          // [RULE22]
  wire [3:0] word_ack = word_len + 4'h1;

  // address decision at the falling clock edge after the eighth bit
  wire addr_hit  = (rx_sh_r[7:1] == own_r);
  wire gen_call  = (rx_sh_r == 8'h00);
  wire decide    = scl_fall & ~bus_evt & (state_r == iss_pkg::ST_ADDR) & (bit_cnt_r == 4'h8);
  wire slv_match = decide & ~mst_r & (addr_hit | gen_call);             // [RULE1]

  // word end, the one moment that raises an interrupt
  wire aack_end  = (state_r == iss_pkg::ST_AACK) & (bit_cnt_r == 4'h9);
  wire dack_end  = (state_r == iss_pkg::ST_DACK) & (bit_cnt_r == word_ack);
  wire irq_ev    = scl_fall & ~bus_evt & (aack_end | dack_end);          // [RULE1] [RULE2]

  // noise check only while master transmitter drives a one
  wire shifting  = (state_r == iss_pkg::ST_ADDR) | (state_r == iss_pkg::ST_DATA);
  // acknowledge bit stays out of the buffer so a read returns the word itself
  wire ack_slot  = (state_r == iss_pkg::ST_AACK) | (state_r == iss_pkg::ST_DACK);
  wire al_set    = scl_rise & mst_r & trx_r & shifting & tx_sh_r[7] & ~sda_s; // [RULE18]

  // clock hold: held while the flag is zero and for the low time after it rises
  wire pin_up    = dbr_acc | (wr_ctrl & w_pin);                          // [RULE4] [RULE9]
  wire hold_scl  = ~pin_r | (rel_cnt_r != 16'h0000);                    // [RULE3]
  wire stop_go   = (state_r == iss_pkg::ST_STOP) & scl_s & ~hold_scl;    // [RULE13]

  // busy shows own clock pin during restart so software can see it let go
  wire bb_view   = restart_r ? scl_oe_r : busy_r;                        // [RULE14]

  // status layout, direction at 6, lost-arb 3, addressed 2, general call 1
  assign status_w = {mst_r, trx_r, bb_view, pin_r, al_r, aas_r, ad0_r, lrb_r}; // [RULE5]

  wire [7:0] rd_mux =
    (reg_addr == `ISS_OFS_CTRL2) ? status_w :
    (reg_addr == `ISS_OFS_DBR)   ? rx_sh_r :
    (reg_addr == `ISS_OFS_CTRL1) ? {wbc_r, ack_en_r, 4'h0} :
    (reg_addr == `ISS_OFS_OWN)   ? {1'b0, own_r} : 8'h00;

  // sequencer; bus conditions override everything since they restart framing
  always_comb
  begin
    state_nxt = state_r;
    if (start_det)
      state_nxt = iss_pkg::ST_ADDR;
    else if (stop_det)
      state_nxt = iss_pkg::ST_IDLE;
    else if (stop_req)
      state_nxt = iss_pkg::ST_STOP;
    else if (scl_fall)
    begin
      unique case (state_r)
        iss_pkg::ST_IDLE: state_nxt = iss_pkg::ST_IDLE;
        iss_pkg::ST_ADDR:
          if (bit_cnt_r == 4'h8)
            state_nxt = (addr_hit | gen_call | mst_r) ? iss_pkg::ST_AACK : iss_pkg::ST_IDLE;
        iss_pkg::ST_AACK:
          if (bit_cnt_r == 4'h9)
            state_nxt = iss_pkg::ST_DATA;
        iss_pkg::ST_DATA:
          if (bit_cnt_r == word_len)
            state_nxt = iss_pkg::ST_DACK;                                // [RULE22]
        iss_pkg::ST_DACK:
          if (bit_cnt_r == word_ack)
            state_nxt = iss_pkg::ST_DATA;
        iss_pkg::ST_STOP: state_nxt = iss_pkg::ST_STOP;
      endcase
    end
  end

  // data pin drive: shifted bit, acknowledge slot or stop low phase
  always_comb
  begin
    sda_low_nxt = 1'b0;
    unique case (state_r)
      iss_pkg::ST_IDLE: sda_low_nxt = 1'b0;
      iss_pkg::ST_ADDR: sda_low_nxt = trx_r & ~tx_sh_r[7];
      iss_pkg::ST_DATA: sda_low_nxt = trx_r & ~tx_sh_r[7];
      iss_pkg::ST_AACK: sda_low_nxt = ~mst_r & aas_r;
      iss_pkg::ST_DACK: sda_low_nxt = ~trx_r & ack_en_r & ~al_r;
      iss_pkg::ST_STOP: sda_low_nxt = stop_sda_r;
    endcase
  end

  // state and bit counter; bits counted on rises, word restarts at fall
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r   <= iss_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      state_r   <= state_nxt;
      if (start_det | irq_ev)
        bit_cnt_r <= 4'h0;
      else if (scl_rise & (state_r != iss_pkg::ST_IDLE) & (state_r != iss_pkg::ST_STOP))
        bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // shift registers and last received bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'hFF;
      lrb_r   <= 1'b0;
    end
    else
    begin
      if (scl_rise & ~ack_slot)
        rx_sh_r <= {rx_sh_r[6:0], sda_s};
      if (scl_rise)
        lrb_r <= sda_s;                                                  // [RULE19]
      if (wr_dbr)
        tx_sh_r <= reg_wdata;
      else if (scl_fall & shifting)
        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
    end
  end

  // mode bits; a lost arbitration wins over a software write in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mst_r <= 1'b0;
      trx_r <= 1'b0;
    end
    else
    begin
      if (al_set)
        mst_r <= 1'b0;                                                   // [RULE2] [RULE18]
      else if (wr_ctrl)
        mst_r <= w_mst;
      if (al_set)
        trx_r <= 1'b0;                                                   // [RULE8]
      else if (slv_match)
        trx_r <= rx_sh_r[0];                                             // [RULE6]
      else if (start_det & ~mst_r)
        trx_r <= 1'b0;
      else if (wr_ctrl)
        trx_r <= w_trx;
    end
  end

  // sticky flags: hardware set beats software clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      al_r  <= 1'b0;
      aas_r <= 1'b0;
      ad0_r <= 1'b0;
    end
    else
    begin
      al_r  <= al_set | (al_r & ~(dbr_acc | wr_ctrl));                   // [RULE8]
      aas_r <= slv_match | (aas_r & ~dbr_acc);                           // [RULE21] [RULE6]
      ad0_r <= (slv_match & gen_call) | (ad0_r & ~bus_evt & ~slv_match); // [RULE6]
    end
  end

  // clock-hold release flag: interrupt clears it, writing zero has no effect
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_r <= `ISS_PIN_RST;
    else if (irq_ev)
      pin_r <= 1'b0;                                                     // [RULE3]
    else if (pin_up)
      pin_r <= 1'b1;                                                     // [RULE20]
  end

  // low-time counter restarts on every release so the clock never shortens
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rel_cnt_r <= 16'h0000;
    else if (pin_up & ~irq_ev)
      rel_cnt_r <= 16'(LOW_CYC);                                         // [RULE4]
    else if (rel_cnt_r != 16'h0000)
      rel_cnt_r <= rel_cnt_r - 16'h0001;
  end

  // stop: data low, wait for line clock high for setup time, then release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stop_sda_r <= 1'b0;
      su_cnt_r   <= 16'h0000;
    end
    else
    begin
      if (stop_req)
        stop_sda_r <= 1'b1;                                              // [RULE11]
      else if (stop_go & (su_cnt_r == 16'(SU_CYC)))
        stop_sda_r <= 1'b0;
      if (~stop_go)
        su_cnt_r <= 16'h0000;                                            // [RULE13]
      else if (su_cnt_r != 16'(SU_CYC))
        su_cnt_r <= su_cnt_r + 16'h0001;
    end
  end

  // bus busy tracks conditions; restart mode holds until the next start or stop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_r    <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      if (start_det)
        busy_r <= 1'b1;
      else if (stop_det)
        busy_r <= 1'b0;
      if (bus_evt)
        restart_r <= 1'b0;
      else if (rst_req)
        restart_r <= 1'b1;                                               // [RULE14] [RULE15]
    end
  end

  // software configuration: bit count, acknowledge enable, own address
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wbc_r    <= `ISS_WBC_RST;
      ack_en_r <= `ISS_ACK_RST;
      own_r    <= `ISS_OWN_RST;
    end
    else
    begin
      if (wr_ctrl1)
        wbc_r <= reg_wdata[`ISS_WBC_HI:`ISS_WBC_LO];                     // [RULE22]
      if (wr_ctrl1)
        ack_en_r <= reg_wdata[`ISS_BIT_ACK];
      if (wr_own)
        own_r <= reg_wdata[6:0];
    end
  end

  // registered outputs; restart forces data released since no stop is wanted
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_r    <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rdata_r  <= 8'h00;
    end
    else
    begin
      irq_r    <= irq_ev;                                                // [RULE1]
      scl_oe_r <= hold_scl;                                              // [RULE3]
      sda_oe_r <= sda_low_nxt & ~al_set & ~rst_req & ~restart_r;         // [RULE18] [RULE14]
      rdata_r  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata     = rdata_r;
  assign scl_oe        = scl_oe_r;
  assign sda_oe        = sda_oe_r;
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign bus_iface_irq = irq_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_pin_low:    assert property (irq_r |-> !pin_r)                                 // [RULE3]
    else $error("release flag not cleared by interrupt");
  a_hold_scl_low:   assert property (!pin_r |=> scl_oe_r)                              // [RULE3]
    else $error("clock not held low while flag is zero");
  a_min_low_time:   assert property ($rose(pin_r) ##1 pin_r [*4] |-> scl_oe_r)         // [RULE4]
    else $error("clock released before low time");
  a_pin_zero_write: assert property (wr_ctrl && !w_pin && pin_r && !irq_ev |=> pin_r)  // [RULE20]
    else $error("writing zero changed release flag");
  a_aas_clear:      assert property (dbr_acc && !slv_match |=> !aas_r)                 // [RULE21]
    else $error("addressed flag survived buffer access");
  a_al_release:     assert property (al_set |=> al_r && !mst_r && !trx_r && !sda_oe_r) // [RULE18]
    else $error("lost arbitration did not drop master");
  a_lrb_capture:    assert property (scl_rise |=> lrb_r == $past(sda_s))               // [RULE19]
    else $error("last bit not captured at clock rise");
  a_read_addr:      assert property (slv_match && rx_sh_r[0] && !gen_call
                                     |=> trx_r && aas_r && !ad0_r)                     // [RULE6]
    else $error("read address status wrong");
  a_stop_begin:     assert property (stop_req && !bus_evt |=> state_r == iss_pkg::ST_STOP
                                     ##1 sda_oe_r)                                     // [RULE11]
    else $error("stop sequence did not start");
  a_stop_postpone:  assert property ((state_r == iss_pkg::ST_STOP) && !scl_s && stop_sda_r
                                     |=> stop_sda_r)                                   // [RULE13]
    else $error("stop issued while clock held low");
  a_restart_free:   assert property (rst_req && !irq_ev |-> ##[1:480] !scl_oe_r)       // [RULE14]
    else $error("restart did not release clock");

  c_slave_hit:  cover property (slv_match ##[1:300] irq_r);
  c_stop_done:  cover property ((state_r == iss_pkg::ST_STOP) ##[1:1000] stop_det);
  c_noise:      cover property (al_set);
  c_restart:    cover property (rst_req ##[1:600] !bb_view);

endmodule

`default_nettype wire

// ===== iss_bus_peer.sv
// behavioural master on the far side of the two-wire lines
`timescale 1ns/1ns
`default_nettype none

module iss_bus_peer (
  // resolved line levels
  input  wire logic scl_ln,
  input  wire logic sda_ln,
  // pull-low drives, high = line pulled low
  output logic      scl_dn,
  output logic      sda_dn
);
  localparam int Q = 40; // quarter of the 160 ns bit period

  // lines idle released; the pull-ups make them high outside frames
  initial
  begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end

  // release the clock and wait out any low hold by the slave, bounded
  task automatic rel_scl();
    int i;
    scl_dn = 1'b0;
    for (i = 0; i < 5000 && scl_ln !== 1'b1; i++) #10;
  endtask

  // one clock pulse: data set while low, sampled at the high phase
  task automatic bit_x(input logic bv, output logic r);
    sda_dn = ~bv;
    #Q rel_scl();
    #Q r = sda_ln;
    #Q scl_dn = 1'b1;
    #Q;
  endtask

  task automatic start_c();
    sda_dn = 1'b1;
    #(2 * Q) scl_dn = 1'b1;
    #Q;
  endtask

  // stop: data low, clock high, then data high
  task automatic stop_c();
    sda_dn = 1'b1;
    #Q rel_scl();
    #(2 * Q) sda_dn = 1'b0;
    #(2 * Q);
  endtask

  // msb first byte, then the acknowledge clock with data released
  task automatic byte_tx(input logic [7:0] v, output logic ack);
    int k;
    logic r;
    for (k = 7; k >= 0; k--) bit_x(v[k], r);
    bit_x(1'b1, ack);
  endtask

  // read a byte; nzb pulls the first bit low as injected noise; ends with a nack
  task automatic byte_rx(input logic nzb, output logic [7:0] v);
    int k;
    logic r;
    for (k = 7; k >= 0; k--)
    begin
      bit_x(!(nzb && k == 7), r);
      v[k] = r;
    end
    bit_x(1'b1, r);
  endtask
endmodule

`default_nettype wire

// ===== iss_core_tb.sv
// self-checking bench for the slave, stop and restart bus block
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
  end

module iss_core_tb;
  localparam int LOW = 8;
  localparam int SU  = 8;
  // clock, reset and register port
  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  // lines; both have pull-ups, so low wins
  logic        scl_oe;
  logic        sda_oe;
  logic        bus_iface_irq;
  logic        m_scl;
  logic        m_sda;
  wire         scl_ln;
  wire         sda_ln;
  // bench state
  logic [15:0] exp_q[$];
  logic [15:0] ent;
  logic        rd_d;
  logic [6:0]  own;
  logic [7:0]  d;
  logic [7:0]  q;
  logic        ack;
  logic        b;
  int          errors;
  int          cmp_count;
  int          cnt;
  int          k;
  int          nz;
  int          seed_v;

  assign scl_ln = ~(scl_oe | m_scl);
  assign sda_ln = ~(sda_oe | m_sda);

  iss_core #(.LOW_CYC(LOW), .SU_CYC(SU)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_ln), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_ln), .sda_o(), .sda_oe(sda_oe), .bus_iface_irq(bus_iface_irq)
  );

  iss_bus_peer m (.scl_ln(scl_ln), .sda_ln(sda_ln), .scl_dn(m_scl), .sda_dn(m_sda));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // a read notes its expected value and mask; the monitor compares
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({mk, e & mk});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_irq();
    int i;
    for (i = 0; i < 2000 && bus_iface_irq !== 1'b1; i++) @(negedge clk);
    `CHK(bus_iface_irq, 1'b1)
    // the clock drive follows the cleared flag one cycle after the pulse
    @(negedge clk);
    `CHK(scl_oe, 1'b1)
  endtask

  // the clock is let go only after the low time has run
  task automatic wait_rel();
    int i;
    for (i = 0; i < 100 && scl_oe !== 1'b0; i++) @(negedge clk);
    `CHK(i >= LOW - 2 && i <= LOW + 2, 1'b1)
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk)
  begin
    if (rd_d === 1'b1)
    begin
      ent = exp_q.pop_front();
      `CHK(reg_rdata & ent[15:8], ent[7:0])
    end
  end

  // watchdog, well beyond the expected run
  initial
  begin
    #800000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    cmp_count = 0;
    seed_v = $urandom(32'h9298);
    own = 7'($urandom_range(127, 2));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped read
    rd(8'h23, 8'h10, 8'hFF);
    rd(8'h20, 8'h00, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    wr(8'h23, 8'h00);
    rd(8'h23, 8'h10, 8'h10);
    $display("test reset done");
    // slave receiver: own address, an 8-bit word, then a 4-bit word
    wr(8'h24, {1'b0, own});
    wr(8'h20, 8'h10);
    d = 8'($urandom);
    fork
      begin
        m.start_c();
        m.byte_tx({own, 1'b0}, ack);
        `CHK(ack, 1'b0)
        m.byte_tx(d, ack);
        for (k = 0; k < 4; k++) m.bit_x(d[k], b);
        m.bit_x(1'b1, ack);
        `CHK(ack, 1'b0)
      end
      begin
        wait_irq();
        rd(8'h23, 8'h24, 8'hFF);
        rd(8'h21, 8'h00, 8'h00);
        wait_rel();
        rd(8'h23, 8'h00, 8'h04);
        wait_irq();
        rd(8'h23, 8'h20, 8'hFF);
        wr(8'h20, 8'h90);
        rd(8'h21, d, 8'hFF);
        wait_rel();
        wait_irq();
        wr(8'h23, 8'h10);
        wait_rel();
      end
    join
    m.stop_c();
    wr(8'h20, 8'h10);
    $display("test slave receive done");
    // general call; writing zero must not set the release flag; restart
    fork
      begin
        m.start_c();
        m.byte_tx(8'h00, ack);
        `CHK(ack, 1'b0)
      end
      begin
        wait_irq();
        rd(8'h23, 8'h26, 8'hFF);
        wr(8'h23, 8'h00);
        rd(8'h23, 8'h00, 8'h10);
        wr(8'h23, 8'h10);
        wait_rel();
        `CHK(sda_oe, 1'b0)
        rd(8'h23, 8'h00, 8'h20);
      end
    join
    m.rel_scl();
    repeat (4) @(negedge clk);
    rd(8'h23, 8'h01, 8'h01);
    repeat (470) @(negedge clk);
    m.stop_c();
    $display("test general call done");
    // slave transmit with nack, then with noise on the first data bit
    for (nz = 0; nz < 2; nz++)
    begin
      d = {1'b1, 7'($urandom)};
      fork
        begin
          m.start_c();
          m.byte_tx({own, 1'b1}, ack);
          m.byte_rx(nz[0], q);
          if (nz == 0) `CHK(q, d)
        end
        begin
          wait_irq();
          rd(8'h23, 8'h64, 8'hFF);
          if (nz == 1) wr(8'h23, 8'hE0);
          wr(8'h21, d);
          wait_rel();
          wait_irq();
          rd(8'h23, nz ? 8'h28 : 8'h61, nz ? 8'hFE : 8'hFF);
          wr(8'h23, 8'h10);
          wait_rel();
        end
      join
      m.stop_c();
    end
    $display("test slave transmit done");
    // foreign address is ignored
    m.start_c();
    m.byte_tx({own ^ 7'h01, 1'b0}, ack);
    `CHK(ack, 1'b1)
    m.stop_c();
    $display("test foreign address done");
    // stop request while the far side holds the clock low
    fork
      begin
        m.start_c();
        m.byte_tx({own, 1'b0}, ack);
      end
      begin
        wait_irq();
        wr(8'h23, 8'hD0);
      end
    join
    repeat (40) @(negedge clk);
    `CHK(sda_oe, 1'b1)
    rd(8'h23, 8'h20, 8'h20);
    m.rel_scl();
    for (cnt = 0; cnt < 200 && sda_oe !== 1'b0; cnt++) @(negedge clk); // no ctrl write until stop
    `CHK(cnt >= SU && cnt <= SU + 6, 1'b1)
    repeat (10) @(negedge clk);
    rd(8'h23, 8'h00, 8'h20);
    repeat (4) @(negedge clk);
    $display("test stop done");
    report_and_stop();
  end
endmodule

`default_nettype wire
